/* File: touch_i2c_consts.svh */
// Purpose: shared constants of the touch controller register-access port
// Assumes: included by its bare name
// Notes:   timing figures are in their own units, counts derive from them
`ifndef TOUCH_I2C_CONSTS_SVH
`define TOUCH_I2C_CONSTS_SVH
`define TI_SLAVE_ADDR     7'h70
`define TI_INIT_TIME_MS   50
`define TI_CLK_FREQ_MHZ   100
`define TI_MAX_RATE_KBPS  400
`define TI_SYNC_STAGES    3
`define TI_START_ADDR_RST 8'h00
`define TI_LAST_BIT       3'h7
`define TI_PIN_IDLE       1'b1
`endif

/* File: touch_i2c_pkg.sv */
// Purpose: types of the touch controller register-access port
// Assumes: nothing
// Notes:   state codes are left to the tools
package touch_i2c_pkg;
  typedef logic [7:0] regByte_t;
  typedef enum {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_RX,
    ST_RX_ACK,
    ST_TX,
    ST_TX_ACK,
    ST_WAIT
  } slvState_t;
endpackage

/* File: i2c_pin_sync.sv */
// Purpose: three-stage sampler of an asynchronous pin
// Assumes: pin idles high (pulled up)
// Notes:   level changes once stages two and three agree
`include "touch_i2c_consts.svh"
module i2c_pin_sync (
  input  wire logic clk_sys,
  input  wire logic rstSn,
  input  wire logic pinI,
  output logic      level
);
  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;
  wire  agree = (stage2_r == stage3_r);

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      stage1_r <= `TI_PIN_IDLE;
      stage2_r <= `TI_PIN_IDLE;
      stage3_r <= `TI_PIN_IDLE;
    end else begin
      stage1_r <= pinI;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      level_r <= `TI_PIN_IDLE;
    end else if (agree) begin
      level_r <= stage3_r;
    end
  end

  assign level = level_r;
endmodule // i2c_pin_sync

/* File: touch_i2c_register_access.sv */
// Purpose: i2c slave giving a host register access to the touch controller
// Assumes: core registers answer regRdData combinationally from regRdAddr
// Notes:   no clock stretching; scl pin is never driven
// Behaviour
// - no access before 50 ms initialisation ends
// - slave only, answers 7-bit address 0x70
// - works at any rate to 400 kbit/s
// - transaction opens with START then address
// - eight-bit bytes, each followed by acknowledge
// - SDA fall while SCL high is START
// - SDA rise while SCL high is STOP
// - SDA changes only while SCL is low
// - read: set address, STOP, then read
// - reads restart at stored start address
// - writes store bytes from given address upward
// - active-low reset restarts initialisation period
// - interrupt line flags new coordinate data
`include "touch_i2c_consts.svh"
module touch_i2c_register_access #(
  parameter int INIT_CYCLES = `TI_INIT_TIME_MS * 1000 * `TI_CLK_FREQ_MHZ
) (
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic                 sclI,
  output logic                      sclO,
  output logic                      sclOe,
  input  wire logic                 sdaI,
  output logic                      sdaO,
  output logic                      sdaOe,
  input  wire logic                 coordReady,
  output logic                      intN,
  output logic                      initDone,
  output touch_i2c_pkg::regByte_t   regRdAddr,
  input  wire touch_i2c_pkg::regByte_t regRdData,
  output logic                      regRdStb,
  output logic                      regWrEn,
  output touch_i2c_pkg::regByte_t   regWrAddr,
  output touch_i2c_pkg::regByte_t   regWrData
);
  import touch_i2c_pkg::*;

  localparam int CW = $clog2(INIT_CYCLES + 1);
  logic          rstPipe1_r;
  logic          rstSn;
  logic [CW-1:0] initCnt_r;
  logic          initDone_r;
  logic          sclF;
  logic          sdaF;
  logic          sclPrev_r;
  logic          sdaPrev_r;
  slvState_t     st_r;
  slvState_t     stNxt;
  logic [2:0]    bitCnt_r;
  logic [2:0]    bitCntNxt;
  regByte_t      rxShift_r;
  regByte_t      rxShiftNxt;
  regByte_t      txShift_r;
  regByte_t      txShiftNxt;
  logic          full_r;
  logic          fullNxt;
  logic          first_r;
  logic          firstNxt;
  logic          rnw_r;
  logic          rnwNxt;
  logic          sdaOe_r;
  logic          sdaOeNxt;
  regByte_t      ptr_r;
  regByte_t      ptrNxt;
  regByte_t      startAddr_r;
  regByte_t      startAddrNxt;
  logic          wrEn_r;
  logic          wrEnNxt;
  regByte_t      wrAddr_r;
  regByte_t      wrAddrNxt;
  regByte_t      wrData_r;
  regByte_t      wrDataNxt;
  logic          rdStb_r;
  logic          rdStbNxt;
  logic          intN_r;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rstPipe1_r <= 1'b0;
      rstSn      <= 1'b0;
    end else begin
      rstPipe1_r <= 1'b1;
      rstSn      <= rstPipe1_r;
    end
  end

  wire initLast = (initCnt_r == CW'(INIT_CYCLES - 1));
  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      initCnt_r  <= '0;
      initDone_r <= 1'b0;
    end else if (!initDone_r) begin
      initCnt_r  <= initCnt_r + CW'(1);
      initDone_r <= initLast;
    end
  end

  // three-stage sampling, far below half a bit
  i2c_pin_sync sclSync (
    .clk_sys (clk_sys),
    .rstSn   (rstSn),
    .pinI    (sclI),
    .level   (sclF)
  );
  i2c_pin_sync sdaSync (
    .clk_sys (clk_sys),
    .rstSn   (rstSn),
    .pinI    (sdaI),
    .level   (sdaF)
  );

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      sclPrev_r <= `TI_PIN_IDLE;
      sdaPrev_r <= `TI_PIN_IDLE;
    end else begin
      sclPrev_r <= sclF;
      sdaPrev_r <= sdaF;
    end
  end

  wire sclRise   = sclF & ~sclPrev_r;
  wire sclFall   = ~sclF & sclPrev_r;
  wire startCond = sclF & sclPrev_r & sdaPrev_r & ~sdaF;
  wire stopCond  = sclF & sclPrev_r & ~sdaPrev_r & sdaF;
  wire addrMatch = (rxShift_r[7:1] == `TI_SLAVE_ADDR) & initDone_r;
  wire lastBit   = (bitCnt_r == `TI_LAST_BIT);

  always_comb begin
    stNxt        = st_r;
    bitCntNxt    = bitCnt_r;
    rxShiftNxt   = rxShift_r;
    txShiftNxt   = txShift_r;
    fullNxt      = full_r;
    firstNxt     = first_r;
    rnwNxt       = rnw_r;
    sdaOeNxt     = sdaOe_r;
    ptrNxt       = ptr_r;
    startAddrNxt = startAddr_r;
    wrEnNxt      = 1'b0;
    wrAddrNxt    = wrAddr_r;
    wrDataNxt    = wrData_r;
    rdStbNxt     = 1'b0;
    if (startCond) begin
      // every transaction opens with the address byte
      stNxt     = ST_ADDR;
      bitCntNxt = 3'h0;
      fullNxt   = 1'b0;
      sdaOeNxt  = 1'b0;
    end else if (stopCond) begin
      stNxt    = ST_IDLE;
      sdaOeNxt = 1'b0;
    end else begin
      unique case (st_r)
        ST_IDLE, ST_WAIT: begin
          sdaOeNxt = 1'b0;
        end
        ST_ADDR, ST_RX: begin
          // eight bits sampled on rising scl
          if (sclRise) begin
            rxShiftNxt = {rxShift_r[6:0], sdaF};
            bitCntNxt  = bitCnt_r + 3'h1;
            fullNxt    = lastBit;
          end else if (sclFall && full_r) begin
            fullNxt = 1'b0;
            if (st_r == ST_ADDR) begin
              if (addrMatch) begin
                // every read starts at the stored address
                stNxt    = ST_ADDR_ACK;
                sdaOeNxt = 1'b1;
                rnwNxt   = rxShift_r[0];
                firstNxt = 1'b1;
                ptrNxt   = startAddr_r;
              end else begin
                stNxt = ST_WAIT;
              end
            end else begin
              stNxt    = ST_RX_ACK;
              sdaOeNxt = 1'b1;
              firstNxt = 1'b0;
              if (first_r) begin
                // write header sets the start address
                startAddrNxt = rxShift_r;
                ptrNxt       = rxShift_r;
              end else begin
                wrEnNxt   = 1'b1;
                wrAddrNxt = ptr_r;
                wrDataNxt = rxShift_r;
                ptrNxt    = ptr_r + 8'h01;
              end
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            bitCntNxt = 3'h0;
            if (rnw_r) begin
              stNxt      = ST_TX;
              sdaOeNxt   = ~regRdData[7];
              txShiftNxt = {regRdData[6:0], 1'b0};
              rdStbNxt   = 1'b1;
            end else begin
              stNxt    = ST_RX;
              sdaOeNxt = 1'b0;
            end
          end
        end
        ST_RX_ACK: begin
          if (sclFall) begin
            stNxt     = ST_RX;
            sdaOeNxt  = 1'b0;
            bitCntNxt = 3'h0;
          end
        end
        ST_TX: begin
          // data moves only after scl has fallen
          if (sclFall) begin
            if (lastBit) begin
              stNxt    = ST_TX_ACK;
              sdaOeNxt = 1'b0;
            end else begin
              sdaOeNxt   = ~txShift_r[7];
              txShiftNxt = {txShift_r[6:0], 1'b0};
              bitCntNxt  = bitCnt_r + 3'h1;
            end
          end
        end
        ST_TX_ACK: begin
          // host acknowledge sampled on rising scl
          if (sclRise) begin
            fullNxt = sdaF;
            ptrNxt  = ptr_r + 8'h01;
          end else if (sclFall) begin
            bitCntNxt = 3'h0;
            if (!full_r) begin
              stNxt      = ST_TX;
              sdaOeNxt   = ~regRdData[7];
              txShiftNxt = {regRdData[6:0], 1'b0};
              rdStbNxt   = 1'b1;
            end else begin
              stNxt   = ST_WAIT;
              fullNxt = 1'b0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      st_r     <= ST_IDLE;
      bitCnt_r <= 3'h0;
      full_r   <= 1'b0;
      first_r  <= 1'b0;
      rnw_r    <= 1'b0;
      sdaOe_r  <= 1'b0;
    end else begin
      st_r     <= stNxt;
      bitCnt_r <= bitCntNxt;
      full_r   <= fullNxt;
      first_r  <= firstNxt;
      rnw_r    <= rnwNxt;
      sdaOe_r  <= sdaOeNxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      rxShift_r   <= 8'h00;
      txShift_r   <= 8'h00;
      ptr_r       <= `TI_START_ADDR_RST;
      startAddr_r <= `TI_START_ADDR_RST;
    end else begin
      rxShift_r   <= rxShiftNxt;
      txShift_r   <= txShiftNxt;
      ptr_r       <= ptrNxt;
      startAddr_r <= startAddrNxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      wrEn_r   <= 1'b0;
      wrAddr_r <= 8'h00;
      wrData_r <= 8'h00;
      rdStb_r  <= 1'b0;
    end else begin
      wrEn_r   <= wrEnNxt;
      wrAddr_r <= wrAddrNxt;
      wrData_r <= wrDataNxt;
      rdStb_r  <= rdStbNxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSn) begin
    if (!rstSn) begin
      intN_r <= 1'b1;
    end else begin
      intN_r <= ~(coordReady & initDone_r);
    end
  end

  assign sclO      = 1'b0;
  assign sclOe     = 1'b0;
  assign sdaO      = 1'b0;
  assign sdaOe     = sdaOe_r;
  assign intN      = intN_r;
  assign initDone  = initDone_r;
  assign regRdAddr = ptr_r;
  assign regRdStb  = rdStb_r;
  assign regWrEn   = wrEn_r;
  assign regWrAddr = wrAddr_r;
  assign regWrData = wrData_r;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstSn);

  init_time_a: assert property ($rose(initDone_r) |-> $past(initCnt_r) == CW'(INIT_CYCLES - 1))
    else $error("initialisation ended at wrong count");
  init_no_ack_a: assert property (!initDone_r |-> !sdaOe_r)
    else $error("sda driven during initialisation");
  addr_match_a: assert property (st_r == ST_ADDR_ACK |-> rxShift_r[7:1] == `TI_SLAVE_ADDR)
    else $error("acknowledged a foreign address");
  start_detect_a: assert property (startCond |=> st_r == ST_ADDR && bitCnt_r == 3'h0)
    else $error("start not recognised");
  stop_detect_a: assert property (stopCond && !startCond |=> st_r == ST_IDLE && !sdaOe_r)
    else $error("stop not recognised");
  drive_scl_low_a: assert property ($rose(sdaOe_r) |-> !sclF)
    else $error("sda pulled while scl high");
  byte_ack_a: assert property (st_r == ST_RX && sclFall && full_r && !startCond && !stopCond
                               |=> st_r == ST_RX_ACK && sdaOe_r)
    else $error("no acknowledge after data byte");
  write_incr_a: assert property (wrEn_r |-> ptr_r == wrAddr_r + 8'h01)
    else $error("write address not stepped");
  read_restart_a: assert property (st_r == ST_ADDR_ACK && rnw_r && sclFall && !startCond
                                   |-> ptr_r == startAddr_r)
    else $error("read does not start at stored address");
  int_follow_a: assert property (coordReady && initDone_r |=> !intN_r)
    else $error("interrupt not raised");

  write_seen_c: cover property (wrEn_r);
  read_seen_c: cover property (rdStb_r ##[1:1000] rdStb_r);
  nack_addr_c: cover property (st_r == ST_ADDR ##1 st_r == ST_WAIT);
  half_bit_c: cover property (sclF [*2] ##1 !sclF);
endmodule // touch_i2c_register_access

/* File: i2c_host_model.sv */
// Purpose: behavioural i2c master standing in for the host microcontroller
// Assumes: caller enters each task just after a system clock edge
// Notes:   scl low 60 ns and high 20 ns per bit; lines released float high
module i2c_host_model (
  input  wire logic sdaW,
  output logic      sclLow,
  output logic      sdaLow
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  task automatic start();
    sdaLow = 1'b0;
    #40;
    sclLow = 1'b0;
    #40;
    sdaLow = 1'b1;
    #40;
    sclLow = 1'b1;
  endtask
  task automatic stop();
    #10;
    sdaLow = 1'b1;
    #30;
    sclLow = 1'b0;
    #40;
    sdaLow = 1'b0;
    #40;
  endtask
  // one bit, data moves while scl low
  // low phase outlasts the slave's sampling delay
  task automatic bitx(input logic b, output logic v);
    #10;
    sdaLow = ~b;
    #50;
    sclLow = 1'b0;
    #20;
    v = sdaW;
    sclLow = 1'b1;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    logic v;
    for (int i = 7; i >= 0; i--) bitx(d[i], v);
    bitx(1'b1, v);
    ack = ~v;
  endtask
  // received byte, host acknowledges unless last
  task automatic recv(input logic nack, output logic [7:0] d);
    logic v;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, v);
      d[i] = v;
    end
    bitx(nack, v);
  endtask
endmodule // i2c_host_model

/* File: touch_i2c_register_access_tb.sv */
// Purpose: self-checking bench of the touch register-access port
// Assumes: register core answers address xor A5
// Notes:   init period shortened by parameter
`include "touch_i2c_consts.svh"
module touch_i2c_register_access_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import touch_i2c_pkg::*;
  localparam int INIT = 300;
  logic     clk_sys, rstn, coordReady, sclO, sclOe, sdaO, sdaOe, intN, initDone;
  logic     regRdStb, regWrEn, sclLow, sdaLow, sclW, sdaW, ack, sclHit;
  regByte_t regRdAddr, regRdData, regWrAddr, regWrData, rb;
  int       n_mismatch, num_checks, cycles, nStb;
  logic [15:0] wq[$];
  assign sclW = ~(sclLow | (sclOe & ~sclO));
  assign sdaW = ~(sdaLow | (sdaOe & ~sdaO));
  assign regRdData = regRdAddr ^ 8'hA5;
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  touch_i2c_register_access #(.INIT_CYCLES(INIT)) touch_i2c_register_access_i (
    .clk_sys(clk_sys), .rstn(rstn), .sclI(sclW), .sclO(sclO), .sclOe(sclOe), .sdaI(sdaW),
    .sdaO(sdaO), .sdaOe(sdaOe), .coordReady(coordReady), .intN(intN), .initDone(initDone),
    .regRdAddr(regRdAddr), .regRdData(regRdData), .regRdStb(regRdStb), .regWrEn(regWrEn),
    .regWrAddr(regWrAddr), .regWrData(regWrData));
  i2c_host_model i2c_host_model_i (.sdaW(sdaW), .sclLow(sclLow), .sdaLow(sdaLow));
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (sclOe === 1'b1) sclHit <= 1'b1;
    if (regWrEn === 1'b1) wq.push_back({regWrAddr, regWrData});
    if (regRdStb === 1'b1) nStb++;
    if (cycles == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic hdr(input logic rd, input logic [6:0] a);
    i2c_host_model_i.start();
    i2c_host_model_i.send({a, rd}, ack);
  endtask
  task automatic rdCheck(input logic [7:0] base, input int n);
    logic [7:0] e;
    nStb = 0;
    hdr(1'b1, `TI_SLAVE_ADDR);
    chk("rd ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      i2c_host_model_i.recv(i == n - 1, rb);
      e = base + i[7:0];
      chk("rd data", rb, e ^ 8'hA5);
    end
    i2c_host_model_i.stop();
    chk("rd strobes", 8'(nStb), 8'(n));
  endtask
  task automatic t_boot(input logic cr);
    int relC;
    rstn = 1'b0;
    cyc(20);
    rstn = 1'b1;
    relC = cycles;
    coordReady = cr;
    cyc(3);
    chk("intN gated", {7'h0, intN}, 8'h01);
    hdr(1'b0, `TI_SLAVE_ADDR);
    chk("early ack", {7'h0, ack}, 8'h00);
    i2c_host_model_i.stop();
    while (cycles < relC + INIT - 10) cyc(1);
    chk("init early", {7'h0, initDone}, 8'h00);
    for (int i = 0; i < 30 && initDone !== 1'b1; i++) cyc(1);
    chk("init done", {7'h0, initDone}, 8'h01);
    coordReady = 1'b0;
  endtask
  task automatic t_addr();
    hdr(1'b0, `TI_SLAVE_ADDR ^ 7'h01);
    chk("other addr", {7'h0, ack}, 8'h00);
    i2c_host_model_i.stop();
  endtask
  task automatic t_write();
    logic [7:0] d[3];
    d = '{8'h11, 8'h22, 8'h33};
    wq.delete();
    hdr(1'b0, `TI_SLAVE_ADDR);
    i2c_host_model_i.send(8'hFE, ack);
    chk("wr ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      i2c_host_model_i.send(d[i], ack);
      chk("wr ack", {7'h0, ack}, 8'h01);
    end
    i2c_host_model_i.stop();
    cyc(2);
    chk("wr count", 8'(wq.size()), 8'h03);
    for (int i = 0; i < 3 && i < wq.size(); i++) begin
      chk("wr addr", wq[i][15:8], 8'hFE + i[7:0]);
      chk("wr data", wq[i][7:0], d[i]);
    end
  endtask
  task automatic t_read();
    hdr(1'b0, `TI_SLAVE_ADDR);
    i2c_host_model_i.send(8'h30, ack);
    chk("ptr ack", {7'h0, ack}, 8'h01);
    i2c_host_model_i.stop();
    rdCheck(8'h30, 3);
    rdCheck(8'h30, 2);
  endtask
  task automatic t_int();
    coordReady = 1'b1;
    cyc(3);
    chk("intN set", {7'h0, intN}, 8'h00);
    coordReady = 1'b0;
    cyc(3);
    chk("intN clr", {7'h0, intN}, 8'h01);
  endtask
  initial begin
    rstn = 1'b0;
    coordReady = 1'b0;
    cycles = 0;
    sclHit = 1'b0;
    n_mismatch = 0;
    num_checks = 0;
    t_boot(1'b0);
    t_addr();
    t_write();
    t_read();
    t_int();
    t_boot(1'b1);
    rdCheck(`TI_START_ADDR_RST, 1);
    chk("scl driven", {7'h0, sclHit}, 8'h00);
    tally_and_finish();
  end
endmodule // touch_i2c_register_access_tb
